// [src/dpl_dev.sv]
// ==========================================================================
// parameter memory, link reload and completion pending flags

// Operation
// (R1) set holds eight words in fixed order
// (R2) upper option fields at fixed bit positions
// (R3) lower option fields at fixed bit positions
// (R4) on completion copy linked set into active
// (R5) software links ping to pong and back
// (R6) software preloads active set with ping
// (R7) ping and pong differ only link, buffer
// (R8) final irq enable reports completion code
// (R9) code n sets pending bit n
// (R10) pending bits stay until software clears
// (R11) software polls pending or uses interrupt
// (R12) link is byte offset, 32-byte sets
module dpl_dev #(
    parameter int CHAN = 3
) (
    input wire logic clk_sys, // system clock
    input wire logic reset_n, // synchronous reset, active low
    dpl_if.dev link, // memory access and pending flags
    input wire logic xfer_done, // pulse: active set fully transferred
    input wire logic xfer_mid, // pulse: one intermediate step done
    input wire logic [2:0] eng_word, // engine word select in active set
    output logic [31:0] eng_rdata, // registered active set word
    output dpl_pkg::dpl_opt_s act_opt, // decoded active option word
    output logic reload_busy, // active set is being reloaded
    output logic done_evt, // pulse: a completion was reported
    output logic chain_evt, // pulse: chaining requested
    output logic [5:0] chain_code // channel to chain to
);

    // ======================================================================
    // state
    typedef enum logic [1:0] {
        DPL_IDLE = 2'b01,
        DPL_RELOAD = 2'b10
    } dpl_dev_st_e;

    typedef struct packed {
        dpl_dev_st_e state;
        logic [2:0] cnt;
        logic [dpl_pkg::PM_AW-1:0] link_base;
        logic ack;
        logic [31:0] rdata;
        logic [dpl_pkg::PEND_W-1:0] pend;
        logic done_evt;
        logic chain_evt;
        logic [dpl_pkg::CODE_W-1:0] chain_code;
        logic [31:0] eng_rdata;
        dpl_pkg::dpl_opt_s channel_options_word;
    } dpl_dev_s;

    localparam logic [dpl_pkg::PM_AW-1:0] ACT_BASE =
        dpl_pkg::PM_AW'(CHAN * dpl_pkg::SET_WORDS);

    dpl_dev_s r_reg;
    dpl_dev_s r_next;

    // idle with every flag cleared; the memory itself keeps its contents
    localparam dpl_dev_s RST_STATE = '{
        state: DPL_IDLE,
        default: '0
    };

    // parameter memory is not reset; software loads every set it uses
    logic [31:0] pm_mem [dpl_pkg::NUM_SETS * dpl_pkg::SET_WORDS];
    logic mem_we;
    logic [dpl_pkg::PM_AW-1:0] mem_waddr;
    logic [31:0] mem_wdata;

    logic [dpl_pkg::PEND_W-1:0] set_bits;
    dpl_pkg::dpl_opt_s cur_opt;
    logic [dpl_pkg::PM_AW-1:0] host_word;
    logic [31:0] link_word;

    function automatic logic [dpl_pkg::PM_AW-1:0] act_word(
        input logic [2:0] idx);
        return ACT_BASE + dpl_pkg::PM_AW'(idx); // see (R1)
    endfunction

    // the link is a byte offset; the bits below a set boundary are dropped,
    // so a careless link can never start a reload in the middle of a set
    function automatic logic [dpl_pkg::PM_AW-1:0] set_base(
        input logic [dpl_pkg::ADDR_W-1:0] byte_off);
        logic [dpl_pkg::PM_AW-1:0] w;
        w = dpl_pkg::dpl_word_addr(byte_off);
        return w & ~dpl_pkg::PM_AW'(dpl_pkg::SET_WORDS - 1); // see (R12)
    endfunction

    // one pending bit per completion code
    function automatic logic [dpl_pkg::PEND_W-1:0] code_bit(
        input logic [dpl_pkg::CODE_W-1:0] code);
        logic [dpl_pkg::PEND_W-1:0] b;
        b = '0;
        b[code] = 1'b1;
        return b;
    endfunction

    // ======================================================================
    // next state
    always_comb begin
        r_next = r_reg;
        r_next.ack = 1'b0;
        r_next.done_evt = 1'b0;
        r_next.chain_evt = 1'b0;
        mem_we = 1'b0;
        mem_waddr = '0;
        mem_wdata = '0;
        set_bits = '0;
        cur_opt = dpl_pkg::dpl_decode_opt(pm_mem[act_word(dpl_pkg::W_OPT)]);
        link_word = pm_mem[act_word(dpl_pkg::W_LINK)];
        host_word = dpl_pkg::dpl_word_addr(link.pm_addr);

        r_next.eng_rdata = pm_mem[act_word(eng_word)];
        r_next.channel_options_word = cur_opt; // see (R2) see (R3)

        case (r_reg.state)
            DPL_IDLE: begin
                // engine completions win over the host: a late reload would
                // let the engine run the finished set a second time
                if (xfer_done) begin
                    if (cur_opt.final_done_irq_enable) begin // see (R8)
                        set_bits = code_bit(
                            cur_opt.completion_code); // see (R9)
                        r_next.done_evt = 1'b1;
                    end
                    if (cur_opt.final_chain_enable) begin
                        r_next.chain_evt = 1'b1;
                        r_next.chain_code = cur_opt.completion_code;
                    end
                    // a static set stays as it is and is never relinked
                    if (!cur_opt.static_set) begin
                        r_next.link_base = set_base(
                            link_word[dpl_pkg::LINK_HI:dpl_pkg::LINK_LO]
                        ); // see (R12)
                        r_next.cnt = '0;
                        r_next.state = DPL_RELOAD; // see (R4)
                    end
                end else if (xfer_mid) begin
                    if (cur_opt.mid_done_irq_enable) begin
                        set_bits = code_bit(
                            cur_opt.completion_code); // see (R9)
                        r_next.done_evt = 1'b1;
                    end
                    if (cur_opt.mid_chain_enable) begin
                        r_next.chain_evt = 1'b1;
                        r_next.chain_code = cur_opt.completion_code;
                    end
                end else if (link.pm_req && !r_reg.ack) begin
                    // host access waits while a reload owns the memory
                    r_next.ack = 1'b1;
                    r_next.rdata = pm_mem[host_word];
                    if (link.pm_we) begin
                        mem_we = 1'b1;
                        mem_waddr = host_word;
                        mem_wdata = link.pm_wdata;
                    end
                end
            end
            DPL_RELOAD: begin
                // one word per cycle, all eight words of the target set
                // host requests wait here: the memory has a single write port
                mem_we = 1'b1;
                mem_waddr = act_word(r_reg.cnt); // see (R4)
                mem_wdata = pm_mem[r_reg.link_base +
                    dpl_pkg::PM_AW'(r_reg.cnt)]; // see (R12)
                r_next.cnt = r_reg.cnt + 3'h1;
                if (r_reg.cnt == dpl_pkg::W_LAST) begin
                    r_next.state = DPL_IDLE;
                end
            end
            default: begin
                r_next.state = DPL_IDLE;
            end
        endcase

        // set wins over a clear landing in the same cycle
        r_next.pend = (r_reg.pend & ~link.pend_clr) | set_bits; // see (R10)
    end

    // ======================================================================
    // registers
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            r_reg <= RST_STATE;
        end else begin
            r_reg <= r_next;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (mem_we) begin
            pm_mem[mem_waddr] <= mem_wdata;
        end
    end

    // ======================================================================
    // outputs
    assign link.pm_ack = r_reg.ack;
    assign link.pm_rdata = r_reg.rdata;
    assign link.pend = r_reg.pend;
    // busy comes from the state register, so the host sees no glitches
    assign link.busy = (r_reg.state == DPL_RELOAD);
    assign eng_rdata = r_reg.eng_rdata;
    assign act_opt = r_reg.channel_options_word;
    assign reload_busy = (r_reg.state == DPL_RELOAD);
    assign done_evt = r_reg.done_evt;
    assign chain_evt = r_reg.chain_evt;
    assign chain_code = r_reg.chain_code;

endmodule

// [common/dpl_pkg.sv]
// ==========================================================================
// shared constants and types
package dpl_pkg;

    // ======================================================================
    // parameter memory geometry
    localparam int SET_WORDS = 8;
    localparam int NUM_SETS = 128;
    localparam int PM_AW = 10;
    localparam int ADDR_W = 16;
    localparam int WORD_W = 32;
    localparam int PEND_W = 64;
    localparam int CODE_W = 6;
    // byte offset bits that select the word inside memory
    localparam int BYTE_LO = 2;
    localparam int BYTE_HI = 11;

    // ======================================================================
    // word order inside one set
    localparam logic [2:0] W_OPT = 3'h0;
    localparam logic [2:0] W_SRC = 3'h1;
    localparam logic [2:0] W_CNT = 3'h2;
    localparam logic [2:0] W_DST = 3'h3;
    localparam logic [2:0] W_BIDX = 3'h4;
    localparam logic [2:0] W_LINK = 3'h5;
    localparam logic [2:0] W_CIDX = 3'h6;
    localparam logic [2:0] W_THIRD_DIM_COUNT = 3'h7;
    localparam logic [2:0] W_LAST = 3'h7;

    // ======================================================================
    // option word field positions
    localparam int B_ACCESS_LEVEL_BIT = 31;
    localparam int B_RQ_HI = 27;
    localparam int B_RQ_LO = 24;
    localparam int B_MID_CHAIN = 23;
    localparam int B_FIN_CHAIN = 22;
    localparam int B_MID_IRQ = 21;
    localparam int B_FIN_IRQ = 20;
    localparam int B_CODE_HI = 17;
    localparam int B_CODE_LO = 12;
    localparam int B_EARLY = 11;
    localparam int B_FW_HI = 10;
    localparam int B_FW_LO = 8;
    localparam int B_STATIC = 3;
    localparam int B_SYNC = 2;
    localparam int B_DAM = 1;
    localparam int B_SAM = 0;

    // link field in the low half of the link word
    localparam int LINK_HI = 15;
    localparam int LINK_LO = 0;

    // ======================================================================
    // controller registers, word offsets on the avalon slave
    localparam logic [2:0] AV_PM_ADDR = 3'h0;
    localparam logic [2:0] AV_PM_DATA = 3'h1;
    localparam logic [2:0] AV_PEND_LO = 3'h2;
    localparam logic [2:0] AV_PEND_HI = 3'h3;
    localparam logic [2:0] AV_STATUS = 3'h4;

    typedef struct packed {
        logic access_level_bit;
        logic [3:0] requester_ident;
        logic mid_chain_enable;
        logic final_chain_enable;
        logic mid_done_irq_enable;
        logic final_done_irq_enable;
        logic [CODE_W-1:0] completion_code;
        logic early_code_mode;
        logic [2:0] fifo_width;
        logic static_set;
        logic sync_dimension;
        logic dest_addr_mode;
        logic source_addr_mode;
    } dpl_opt_s;

    function automatic dpl_opt_s dpl_decode_opt(input logic [31:0] w);
        dpl_opt_s o;
        o.access_level_bit = w[B_ACCESS_LEVEL_BIT];
        o.requester_ident = w[B_RQ_HI:B_RQ_LO];
        o.mid_chain_enable = w[B_MID_CHAIN];
        o.final_chain_enable = w[B_FIN_CHAIN];
        o.mid_done_irq_enable = w[B_MID_IRQ];
        o.final_done_irq_enable = w[B_FIN_IRQ];
        o.completion_code = w[B_CODE_HI:B_CODE_LO];
        o.early_code_mode = w[B_EARLY];
        o.fifo_width = w[B_FW_HI:B_FW_LO];
        o.static_set = w[B_STATIC];
        o.sync_dimension = w[B_SYNC];
        o.dest_addr_mode = w[B_DAM];
        o.source_addr_mode = w[B_SAM];
        return o;
    endfunction

    // byte offset into parameter memory to word index
    function automatic logic [PM_AW-1:0] dpl_word_addr(
        input logic [ADDR_W-1:0] byte_off);
        return byte_off[BYTE_HI:BYTE_LO];
    endfunction

endpackage

// [common/dpl_if.sv]
// ==========================================================================
// link between parameter-memory owner and its controlling party
interface dpl_if;
    logic pm_req;
    logic pm_we;
    logic [dpl_pkg::ADDR_W-1:0] pm_addr;
    logic [dpl_pkg::WORD_W-1:0] pm_wdata;
    logic [dpl_pkg::WORD_W-1:0] pm_rdata;
    logic pm_ack;
    logic [dpl_pkg::PEND_W-1:0] pend;
    logic [dpl_pkg::PEND_W-1:0] pend_clr;
    logic busy;

    modport dev (
        input pm_req, pm_we, pm_addr, pm_wdata, pend_clr,
        output pm_rdata, pm_ack, pend, busy
    );
    modport host (
        output pm_req, pm_we, pm_addr, pm_wdata, pend_clr,
        input pm_rdata, pm_ack, pend, busy
    );
endinterface

// [src/dpl_host.sv]
// ==========================================================================
// software-facing controller: avalon slave driving the link
module dpl_host (
    input wire logic clk_sys, // system clock
    input wire logic reset_n, // synchronous reset, active low
    dpl_if.host link, // memory access and pending flags
    input wire logic [2:0] avs_address, // word offset
    input wire logic avs_read, // read request
    input wire logic avs_write, // write request
    input wire logic [31:0] avs_writedata, // write data
    output logic [31:0] avs_readdata, // read data
    output logic avs_waitrequest // high while access not done
);

    // ======================================================================
    // state
    typedef enum logic [2:0] {
        DPL_H_IDLE = 3'b001,
        DPL_H_WAIT = 3'b010,
        DPL_H_FIN = 3'b100
    } dpl_host_st_e;

    typedef struct packed {
        dpl_host_st_e state;
        logic [dpl_pkg::ADDR_W-1:0] pm_addr;
        logic pm_we;
        logic [31:0] pm_wdata;
        logic [31:0] rdata;
        logic [dpl_pkg::PEND_W-1:0] clr;
    } dpl_host_s;

    dpl_host_s r_reg;
    dpl_host_s r_next;

    function automatic logic [31:0] reg_read(input logic [2:0] a,
        input dpl_host_s s);
        case (a)
            dpl_pkg::AV_PM_ADDR: return {16'h0000, s.pm_addr};
            dpl_pkg::AV_PEND_LO: return link.pend[31:0]; // see (R11)
            dpl_pkg::AV_PEND_HI: return link.pend[63:32];
            dpl_pkg::AV_STATUS: return {31'h00000000, link.busy};
            default: return 32'h00000000;
        endcase
    endfunction

    // ======================================================================
    // next state
    always_comb begin
        r_next = r_reg;
        r_next.clr = '0;
        case (r_reg.state)
            DPL_H_IDLE: begin
                if (avs_read || avs_write) begin
                    if (avs_address == dpl_pkg::AV_PM_DATA) begin
                        // sets are loaded word by word: see (R5) see (R6)
                        r_next.pm_we = avs_write;
                        r_next.pm_wdata = avs_writedata;
                        r_next.state = DPL_H_WAIT;
                    end else begin
                        r_next.rdata = reg_read(avs_address, r_reg);
                        r_next.state = DPL_H_FIN;
                    end
                end
            end
            DPL_H_WAIT: begin
                if (link.pm_ack) begin
                    r_next.rdata = link.pm_rdata;
                    r_next.state = DPL_H_FIN;
                end
            end
            DPL_H_FIN: begin
                r_next.state = DPL_H_IDLE;
                if (avs_write) begin
                    case (avs_address)
                        dpl_pkg::AV_PM_ADDR:
                            r_next.pm_addr = avs_writedata[15:0];
                        dpl_pkg::AV_PEND_LO:
                            r_next.clr[31:0] = avs_writedata; // see (R10)
                        dpl_pkg::AV_PEND_HI:
                            r_next.clr[63:32] = avs_writedata; // see (R10)
                        default: begin
                        end
                    endcase
                end
            end
            default: begin
                r_next.state = DPL_H_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            r_reg <= '0;
            r_reg.state <= DPL_H_IDLE;
        end else begin
            r_reg <= r_next;
        end
    end

    // ======================================================================
    // outputs
    assign link.pm_req = (r_reg.state == DPL_H_WAIT);
    assign link.pm_we = r_reg.pm_we;
    assign link.pm_addr = r_reg.pm_addr;
    assign link.pm_wdata = r_reg.pm_wdata;
    assign link.pend_clr = r_reg.clr;
    assign avs_readdata = r_reg.rdata;
    assign avs_waitrequest = (r_reg.state != DPL_H_FIN);

endmodule

// [bench/dpl_assertions.sv]
// ==========================================================================
// link protocol checks between the two ends
module dpl_assertions (
    input wire logic clk_sys, // clock
    input wire logic reset_n, // reset
    input wire logic pm_req, // request
    input wire logic pm_we, // write
    input wire logic [dpl_pkg::ADDR_W-1:0] pm_addr, // offset
    input wire logic [dpl_pkg::WORD_W-1:0] pm_wdata, // wdata
    input wire logic pm_ack, // answer
    input wire logic [dpl_pkg::PEND_W-1:0] pend, // flags
    input wire logic [dpl_pkg::PEND_W-1:0] pend_clr, // clears
    input wire logic busy // reload
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!reset_n);
    sequence s_reload;
        busy [*8] ##1 !busy;
    endsequence
    sequence s_held;
        pm_req && $stable(pm_addr) && $stable(pm_we) && $stable(pm_wdata);
    endsequence
    chk_reload_len: assert property ($rose(busy) |-> s_reload)
        else $error("reload not eight cycles");
    chk_req_held: assert property (pm_req && !pm_ack |=> s_held)
        else $error("request changed before answer");
    chk_ack_pulse: assert property (pm_ack |=> !pm_ack && !pm_req)
        else $error("answer or request stayed up");
    chk_ack_idle: assert property (
        pm_ack |-> $past(pm_req) && !$past(busy))
        else $error("answer without request or in reload");
    chk_clr_pulse: assert property (|pend_clr |=> pend_clr == '0)
        else $error("clear pulse too long");
    chk_pend_sticky: assert property (
        ($past(pend) & ~pend & ~$past(pend_clr)) == '0)
        else $error("pending bit fell without clear");
    chk_one_set: assert property (
        $countones(pend & ~$past(pend)) <= 1)
        else $error("several pending bits rose");
    chk_clr_effect: assert property (
        |pend_clr |=> ($past(pend_clr) & $past(pend) & pend) == '0)
        else $error("clear did not take effect");
    chk_req_gap: assert property ($fell(pm_req) |=> !pm_req)
        else $error("requests too close");
endmodule

// [bench/dpl_parameter_memory_link_pingpong_tb_top.sv]
module dpl_parameter_memory_link_pingpong_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int CHAN = 3;
    logic clk_sys = 1'b0;
    logic reset_n = 1'b0;
    logic [2:0] avs_address = 3'h0;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic xfer_done = 1'b0;
    logic xfer_mid = 1'b0;
    logic [2:0] eng_word = 3'h0;
    logic [31:0] eng_rdata;
    dpl_pkg::dpl_opt_s act_opt;
    logic reload_busy, done_evt, chain_evt;
    logic [5:0] chain_code;
    logic [31:0] mem [0:127][0:7];
    logic [31:0] base [0:7];
    logic [63:0] pend_exp = 64'h0;
    logic [31:0] seed = 32'h6;
    int err_count = 0;
    int n_tests = 0;

    always #10 clk_sys = ~clk_sys;

    dpl_if i_dpl_if ();
    dpl_dev #(.CHAN(CHAN)) i_dpl_dev (.clk_sys(clk_sys), .reset_n(reset_n),
        .link(i_dpl_if), .xfer_done(xfer_done), .xfer_mid(xfer_mid),
        .eng_word(eng_word), .eng_rdata(eng_rdata), .act_opt(act_opt),
        .reload_busy(reload_busy), .done_evt(done_evt),
        .chain_evt(chain_evt), .chain_code(chain_code));
    dpl_host i_dpl_host (.clk_sys(clk_sys), .reset_n(reset_n),
        .link(i_dpl_if), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));
    dpl_assertions i_dpl_assertions (.clk_sys(clk_sys), .reset_n(reset_n),
        .pm_req(i_dpl_if.pm_req), .pm_we(i_dpl_if.pm_we),
        .pm_addr(i_dpl_if.pm_addr), .pm_wdata(i_dpl_if.pm_wdata),
        .pm_ack(i_dpl_if.pm_ack), .pend(i_dpl_if.pend),
        .pend_clr(i_dpl_if.pend_clr), .busy(i_dpl_if.busy));

    // ======================================================================
    // helpers
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    function automatic logic [63:0] opt_fields(input logic [31:0] w);
        return {41'h0, w[31], w[27:24], w[23], w[22], w[21], w[20],
            w[17:12], w[11], w[10:8], w[3], w[2], w[1], w[0]};
    endfunction

    task automatic check(input string nm, input logic [63:0] e,
        input logic [63:0] g);
        n_tests++;
        if (g !== e) begin
            err_count++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic av(input bit wr, input logic [2:0] a,
        input logic [31:0] d, output logic [31:0] q);
        int n;
        n = 0;
        @(posedge clk_sys);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= wr;
        avs_read <= !wr;
        do begin
            @(posedge clk_sys);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 50);
        q = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        if (n >= 50) check("avalon_wait", 0, 1);
    endtask

    task automatic rd_pend();
        logic [31:0] lo, hi;
        av(1'b0, 3'h2, 32'h0, lo);
        av(1'b0, 3'h3, 32'h0, hi);
        check("pend", pend_exp, {hi, lo});
    endtask

    task automatic clr(input logic [63:0] m);
        logic [31:0] q;
        av(1'b1, 3'h2, m[31:0], q);
        av(1'b1, 3'h3, m[63:32], q);
        pend_exp &= ~m;
        rd_pend();
    endtask

    task automatic load_set(input int s, input int lk, input logic [31:0] dst);
        logic [31:0] d, q;
        for (int k = 0; k < 8; k++) begin
            d = (k == 3) ? dst : base[k];
            // junk in the low link bits must be ignored by the reload
            if (k == 5) d[15:0] = 16'(lk * 32 + int'(base[5][4:0]));
            av(1'b1, 3'h0, 32'(s * 32 + k * 4), q);
            av(1'b1, 3'h1, d, q);
            mem[s][k] = d;
        end
    endtask

    task automatic pulse(input bit mid);
        logic [31:0] w, q;
        logic [6:0] lk;
        bit go;
        int n;
        w = mem[CHAN][0];
        lk = mem[CHAN][5][11:5];
        go = !mid && !w[3];
        @(posedge clk_sys);
        xfer_mid <= mid;
        xfer_done <= !mid;
        @(posedge clk_sys);
        xfer_mid <= 1'b0;
        xfer_done <= 1'b0;
        #1;
        check("done_evt", mid ? w[21] : w[20], done_evt);
        check("chain_evt", mid ? w[23] : w[22], chain_evt);
        if (mid ? w[23] : w[22])
            check("chain_code", w[17:12], chain_code);
        check("reload_busy", go, reload_busy);
        if (mid ? w[21] : w[20]) pend_exp[w[17:12]] = 1'b1;
        if (go) begin
            av(1'b0, 3'h4, 32'h0, q);
            check("status", 1, q);
            @(posedge clk_sys);
            xfer_done <= 1'b1;
            @(posedge clk_sys);
            xfer_done <= 1'b0;
            #1;
            check("ignored_done", 0, done_evt);
            for (int k = 0; k < 8; k++) mem[CHAN][k] = mem[lk][k];
            n = 0;
            while (reload_busy !== 1'b0 && n < 20) begin
                @(posedge clk_sys);
                n++;
            end
            check("busy_end", 0, reload_busy);
        end
        rd_pend();
    endtask

    task tally_and_finish;
        $display("checks %0d mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // ======================================================================
    // main sequence
    initial begin
        logic [31:0] q, w;
        repeat (6) @(posedge clk_sys);
        reset_n <= 1'b1;
        rd_pend();
        av(1'b1, 3'h5, 32'hffff_ffff, q);
        av(1'b0, 3'h5, 32'h0, q);
        check("unmapped", 0, q);
        av(1'b1, 3'h4, 32'h0000_00ff, q);
        av(1'b0, 3'h4, 32'h0, q);
        check("status_idle", 0, q);
        w = xs();
        av(1'b1, 3'h0, w, q);
        av(1'b0, 3'h0, 32'h0, q);
        check("pm_addr", {16'h0, w[15:0]}, q);
        // completion codes 3 and 2 first, then random, then a static set
        for (int r = 0; r < 4; r++) begin
            for (int k = 0; k < 8; k++) base[k] = xs();
            base[0] = (r == 0) ? 32'h0010_3000 : (r == 1) ? 32'h00d0_2000 :
                (r == 2) ? (base[0] & ~32'h8) : (base[0] | 32'h8);
            load_set(65, 64, base[3]);
            load_set(64, 65, xs());
            load_set(CHAN, 64, base[3]);
            pulse(1'b1);
            for (int i = 0; i < 3; i++) pulse(1'b0);
            for (int k = 0; k < 8; k++) begin
                @(posedge clk_sys);
                eng_word <= 3'(k);
                @(posedge clk_sys);
                #1;
                check("active_word", mem[CHAN][k], eng_rdata);
            end
            w = mem[CHAN][0];
            check("act_opt", opt_fields(w), 64'(act_opt));
            w = xs();
            av(1'b1, 3'h0, 32'(CHAN * 32 + int'(w[2:0]) * 4), q);
            av(1'b0, 3'h1, 32'h0, q);
            check("pm_data", mem[CHAN][w[2:0]], q);
            clr({xs(), xs()} & pend_exp);
            clr(pend_exp);
        end
        tally_and_finish();
    end

    initial begin
        #400000;
        err_count++;
        tally_and_finish();
    end
endmodule
